// file: rtl/lio_pkg.sv
// Constants and types shared by the low I/O register block.
// Assumes a single 20 MHz clock domain and a synchronous reset.
package lio_pkg;

  // Clock rate, kept for reference by users of the block
  localparam int CLK_PERIOD_NS = 50;

  // Address space limits, as seen on the core access port
  localparam int ADDR_W = 16;
  localparam logic [15:0] IO_SPACE_SIZE = 16'h0040;
  localparam logic [15:0] BIT_SPACE_TOP = 16'h001F;
  localparam logic [15:0] DATA_OFFSET = 16'h0020;
  localparam logic [15:0] EXT_FIRST = 16'h0060;
  localparam logic [15:0] EXT_LAST = 16'h01FF;

  // I/O addresses of the implemented registers
  localparam logic [5:0] OFF_PORT_B_INPUT = 6'h03;
  localparam logic [5:0] OFF_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] OFF_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] OFF_PORT_C_INPUT = 6'h06;
  localparam logic [5:0] OFF_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] OFF_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] OFF_PORT_D_INPUT = 6'h09;
  localparam logic [5:0] OFF_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] OFF_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] OFF_PORT_E_INPUT = 6'h0C;
  localparam logic [5:0] OFF_PORT_E_DIRECTION = 6'h0D;
  localparam logic [5:0] OFF_PORT_E_OUTPUT = 6'h0E;
  localparam logic [5:0] OFF_PORT_F_INPUT = 6'h0F;
  localparam logic [5:0] OFF_PORT_F_DIRECTION = 6'h10;
  localparam logic [5:0] OFF_PORT_F_OUTPUT = 6'h11;
  localparam logic [5:0] OFF_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] OFF_TIMER1_FLAGS = 6'h16;

  // Implemented bits of each register group
  localparam logic [7:0] MASK_PORT_B = 8'hFF;
  localparam logic [7:0] MASK_PORT_C = 8'hC0;
  localparam logic [7:0] MASK_PORT_D = 8'hFF;
  localparam logic [7:0] MASK_PORT_E = 8'h44;
  localparam logic [7:0] MASK_PORT_F = 8'hF3;
  localparam logic [7:0] MASK_TIMER0 = 8'h07;
  localparam logic [7:0] MASK_TIMER1 = 8'h2F;

  // Flag bit positions
  localparam int T0_OVERFLOW_BIT = 0;
  localparam int T0_MATCH_A_BIT = 1;
  localparam int T0_MATCH_B_BIT = 2;
  localparam int T1_OVERFLOW_BIT = 0;
  localparam int T1_MATCH_A_BIT = 1;
  localparam int T1_MATCH_B_BIT = 2;
  localparam int T1_MATCH_C_BIT = 3;
  localparam int T1_CAPTURE_BIT = 5;

  // Reset value of every register, and the single-bit mask base
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ONE_BIT = 8'h01;

  // Access kinds presented by the core
  typedef enum logic [2:0] {
    IO_READ_OP = 3'h0,
    IO_WRITE_OP = 3'h1,
    MEMORY_READ_OP = 3'h2,
    MEMORY_WRITE_OP = 3'h3,
    BIT_SET_OP = 3'h4,
    BIT_CLEAR_OP = 3'h5,
    SKIP_IF_BIT_SET = 3'h6,
    SKIP_IF_BIT_CLEAR = 3'h7
  } lio_op_type;

endpackage

// file: rtl/lio_port.sv
// One general-purpose port: direction, output and pin-input registers.
// Assumes pins arrive asynchronously and writes come from the decoder.
`timescale 1ns/1ns
module lio_port
  import lio_pkg::*;
#(
  parameter logic [7:0] PORT_MASK = 8'hFF
)
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] pin_i, // Pin levels, asynchronous
  input wire logic dir_we_i, // Direction register write strobe
  input wire logic out_we_i, // Output register write strobe
  input wire logic [7:0] wdata_i, // Write data
  output logic [7:0] input_o, // Synchronised pin levels
  output logic [7:0] direction_o, // Direction register
  output logic [7:0] output_o, // Output register
  output logic [7:0] pin_o, // Pin drive level
  output logic [7:0] pin_oe_o // Pin drive enable
);

  logic [7:0] sync_first;
  logic [7:0] sync_second;
  logic [7:0] direction;
  logic [7:0] out_level;

  // Two-stage synchroniser on the pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_first <= RESET_BYTE;
      sync_second <= RESET_BYTE;
    end
    else
    begin
      sync_first <= pin_i;
      sync_second <= sync_first;
    end
  end

  // Direction register, absent bits held at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      direction <= RESET_BYTE;
    else if (dir_we_i)
      direction <= wdata_i & PORT_MASK;
  end

  // Output register, absent bits held at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_level <= RESET_BYTE;
    else if (out_we_i)
      out_level <= wdata_i & PORT_MASK;
  end

  // Read values and pin drive
  assign input_o = sync_second & PORT_MASK;
  assign direction_o = direction;
  assign output_o = out_level;
  assign pin_o = out_level;
  assign pin_oe_o = direction;

endmodule

// file: rtl/lio_regs.sv
// Low I/O register space: five ports and two timer flag registers,
// reached by the core through I/O, data-space and single-bit accesses.
// Assumes one access per cycle from the core, timer events as
// same-clock pulses, and pins that are asynchronous to the clock.
//
// Functional notes
// - bit set and bit clear work on I/O 0x00 to 0x1F only.
// - skip tests on a single bit work on I/O 0x00 to 0x1F.
// - timer flags clear on a written one; a zero leaves them.
// - bit set or clear rewrites the whole register, clearing set flags other than the one addressed by a bit clear.
// - I/O read and write reach only the first 64 locations.
// - data-space address equals I/O address plus 0x20.
// - extended area is reached by data-space accesses only.
// - port B has full input, direction, output at 0x03 to 0x05.
// - port D has full input, direction, output at 0x09 to 0x0B.
// - port F at 0x0F to 0x11 lacks bits 3 and 2.
// - timer 1 flags: capture 5, match C 3, B 2, A 1, overflow 0.
// - timer 0 flags: match B 2, match A 1, overflow 0.
`timescale 1ns/1ns
module lio_regs
  import lio_pkg::*;
(
  input wire logic clk_i, // System clock, 20 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic acc_valid_i, // Access request from the core
  input wire lio_op_type acc_op_i, // Access kind
  input wire logic [15:0] acc_addr_i, // I/O or data-space address
  input wire logic [2:0] acc_bit_i, // Bit number for bit accesses
  input wire logic [7:0] acc_wdata_i, // Write data
  output logic acc_ack_o, // Answer strobe, one cycle
  output logic [7:0] acc_rdata_o, // Read data
  output logic acc_skip_o, // Skip decision of a bit test
  output logic acc_err_o, // Access refused
  input wire logic [7:0] timer0_set_i, // Timer 0 flag set pulses
  input wire logic [7:0] timer1_set_i, // Timer 1 flag set pulses
  output logic [7:0] timer0_flags_o, // Timer 0 flag register
  output logic [7:0] timer1_flags_o, // Timer 1 flag register
  input wire logic [7:0] pin_b_i, // Port B pin levels
  output logic [7:0] pin_b_o, // Port B drive level
  output logic [7:0] pin_b_oe_o, // Port B drive enable
  input wire logic [7:0] pin_c_i, // Port C pin levels
  output logic [7:0] pin_c_o, // Port C drive level
  output logic [7:0] pin_c_oe_o, // Port C drive enable
  input wire logic [7:0] pin_d_i, // Port D pin levels
  output logic [7:0] pin_d_o, // Port D drive level
  output logic [7:0] pin_d_oe_o, // Port D drive enable
  input wire logic [7:0] pin_e_i, // Port E pin levels
  output logic [7:0] pin_e_o, // Port E drive level
  output logic [7:0] pin_e_oe_o, // Port E drive enable
  input wire logic [7:0] pin_f_i, // Port F pin levels
  output logic [7:0] pin_f_o, // Port F drive level
  output logic [7:0] pin_f_oe_o // Port F drive enable
);

  logic [15:0] mem_io_addr;
  logic [5:0] io_addr;
  logic io_ok;
  logic refuse;
  logic is_write;
  logic is_read;
  logic is_skip;
  logic wr_req;
  logic [7:0] bit_mask;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic [7:0] port_b_input;
  logic [7:0] port_b_direction;
  logic [7:0] port_b_output;
  logic [7:0] port_c_input;
  logic [7:0] port_c_direction;
  logic [7:0] port_c_output;
  logic [7:0] port_d_input;
  logic [7:0] port_d_direction;
  logic [7:0] port_d_output;
  logic [7:0] port_e_input;
  logic [7:0] port_e_direction;
  logic [7:0] port_e_output;
  logic [7:0] port_f_input;
  logic [7:0] port_f_direction;
  logic [7:0] port_f_output;
  logic [7:0] timer0_flags;
  logic [7:0] timer1_flags;
  logic [7:0] timer0_clear;
  logic [7:0] timer1_clear;

  // Data-space address folded back onto the I/O space
  assign mem_io_addr = acc_addr_i - DATA_OFFSET;

  // Address decode per access kind
  always_comb
  begin
    io_ok = 1'b0;
    refuse = 1'b0;
    io_addr = 6'h00;
    case (acc_op_i)
      IO_READ_OP, IO_WRITE_OP:
      begin
        if (acc_addr_i < IO_SPACE_SIZE)
        begin
          io_ok = 1'b1;
          io_addr = acc_addr_i[5:0];
        end
        else
          refuse = 1'b1;
      end
      BIT_SET_OP, BIT_CLEAR_OP, SKIP_IF_BIT_SET, SKIP_IF_BIT_CLEAR:
      begin
        if (acc_addr_i <= BIT_SPACE_TOP)
        begin
          io_ok = 1'b1;
          io_addr = acc_addr_i[5:0];
        end
        else
          refuse = 1'b1;
      end
      MEMORY_READ_OP, MEMORY_WRITE_OP:
      begin
        if (acc_addr_i >= DATA_OFFSET && acc_addr_i < EXT_FIRST)
        begin
          io_ok = 1'b1;
          io_addr = mem_io_addr[5:0];
        end
        else if (acc_addr_i >= EXT_FIRST && acc_addr_i <= EXT_LAST)
          refuse = 1'b0; // accepted, nothing mapped here
        else
          refuse = 1'b1;
      end
      default:
        refuse = 1'b1;
    endcase
  end

  // Access kind groups
  assign is_write = (acc_op_i == IO_WRITE_OP) ||
                    (acc_op_i == MEMORY_WRITE_OP) ||
                    (acc_op_i == BIT_SET_OP) ||
                    (acc_op_i == BIT_CLEAR_OP);
  assign is_read = (acc_op_i == IO_READ_OP) ||
                   (acc_op_i == MEMORY_READ_OP);
  assign is_skip = (acc_op_i == SKIP_IF_BIT_SET) ||
                   (acc_op_i == SKIP_IF_BIT_CLEAR);
  assign wr_req = acc_valid_i && io_ok && is_write;
  assign bit_mask = ONE_BIT << acc_bit_i;

  // Read multiplexer; reserved and unmapped locations read zero
  always_comb
  begin
    if (io_addr == OFF_PORT_B_INPUT)
      rd_val = port_b_input;
    else if (io_addr == OFF_PORT_B_DIRECTION)
      rd_val = port_b_direction;
    else if (io_addr == OFF_PORT_B_OUTPUT)
      rd_val = port_b_output;
    else if (io_addr == OFF_PORT_C_INPUT)
      rd_val = port_c_input;
    else if (io_addr == OFF_PORT_C_DIRECTION)
      rd_val = port_c_direction;
    else if (io_addr == OFF_PORT_C_OUTPUT)
      rd_val = port_c_output;
    else if (io_addr == OFF_PORT_D_INPUT)
      rd_val = port_d_input;
    else if (io_addr == OFF_PORT_D_DIRECTION)
      rd_val = port_d_direction;
    else if (io_addr == OFF_PORT_D_OUTPUT)
      rd_val = port_d_output;
    else if (io_addr == OFF_PORT_E_INPUT)
      rd_val = port_e_input;
    else if (io_addr == OFF_PORT_E_DIRECTION)
      rd_val = port_e_direction;
    else if (io_addr == OFF_PORT_E_OUTPUT)
      rd_val = port_e_output;
    else if (io_addr == OFF_PORT_F_INPUT)
      rd_val = port_f_input;
    else if (io_addr == OFF_PORT_F_DIRECTION)
      rd_val = port_f_direction;
    else if (io_addr == OFF_PORT_F_OUTPUT)
      rd_val = port_f_output;
    else if (io_addr == OFF_TIMER0_FLAGS)
      rd_val = timer0_flags;
    else if (io_addr == OFF_TIMER1_FLAGS)
      rd_val = timer1_flags;
    else
      rd_val = RESET_BYTE;
  end

  // Write value; bit accesses modify the whole register just read
  always_comb
  begin
    if (acc_op_i == BIT_SET_OP)
      wr_val = rd_val | bit_mask;
    else if (acc_op_i == BIT_CLEAR_OP)
      wr_val = rd_val & ~bit_mask;
    else
      wr_val = acc_wdata_i;
  end

  // Port B, all eight bits
  lio_port #(
    .PORT_MASK(MASK_PORT_B)
  ) u_port_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_b_i),
    .dir_we_i(wr_req && io_addr == OFF_PORT_B_DIRECTION),
    .out_we_i(wr_req && io_addr == OFF_PORT_B_OUTPUT),
    .wdata_i(wr_val),
    .input_o(port_b_input),
    .direction_o(port_b_direction),
    .output_o(port_b_output),
    .pin_o(pin_b_o),
    .pin_oe_o(pin_b_oe_o)
  );

  // Port C, bits 7 and 6
  lio_port #(
    .PORT_MASK(MASK_PORT_C)
  ) u_port_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_c_i),
    .dir_we_i(wr_req && io_addr == OFF_PORT_C_DIRECTION),
    .out_we_i(wr_req && io_addr == OFF_PORT_C_OUTPUT),
    .wdata_i(wr_val),
    .input_o(port_c_input),
    .direction_o(port_c_direction),
    .output_o(port_c_output),
    .pin_o(pin_c_o),
    .pin_oe_o(pin_c_oe_o)
  );

  // Port D, all eight bits
  lio_port #(
    .PORT_MASK(MASK_PORT_D)
  ) u_port_d (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_d_i),
    .dir_we_i(wr_req && io_addr == OFF_PORT_D_DIRECTION),
    .out_we_i(wr_req && io_addr == OFF_PORT_D_OUTPUT),
    .wdata_i(wr_val),
    .input_o(port_d_input),
    .direction_o(port_d_direction),
    .output_o(port_d_output),
    .pin_o(pin_d_o),
    .pin_oe_o(pin_d_oe_o)
  );

  // Port E, bits 6 and 2
  lio_port #(
    .PORT_MASK(MASK_PORT_E)
  ) u_port_e (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_e_i),
    .dir_we_i(wr_req && io_addr == OFF_PORT_E_DIRECTION),
    .out_we_i(wr_req && io_addr == OFF_PORT_E_OUTPUT),
    .wdata_i(wr_val),
    .input_o(port_e_input),
    .direction_o(port_e_direction),
    .output_o(port_e_output),
    .pin_o(pin_e_o),
    .pin_oe_o(pin_e_oe_o)
  );

  // Port F, bits 3 and 2 absent
  lio_port #(
    .PORT_MASK(MASK_PORT_F)
  ) u_port_f (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_f_i),
    .dir_we_i(wr_req && io_addr == OFF_PORT_F_DIRECTION),
    .out_we_i(wr_req && io_addr == OFF_PORT_F_OUTPUT),
    .wdata_i(wr_val),
    .input_o(port_f_input),
    .direction_o(port_f_direction),
    .output_o(port_f_output),
    .pin_o(pin_f_o),
    .pin_oe_o(pin_f_oe_o)
  );

  // Flag clears: a one written to a flag position clears it
  assign timer0_clear = (wr_req && io_addr == OFF_TIMER0_FLAGS) ?
                        (wr_val & MASK_TIMER0) : RESET_BYTE;
  assign timer1_clear = (wr_req && io_addr == OFF_TIMER1_FLAGS) ?
                        (wr_val & MASK_TIMER1) : RESET_BYTE;

  // Timer 0 flags; a set in the clearing cycle survives
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer0_flags <= RESET_BYTE;
    else
      timer0_flags <= ((timer0_flags & ~timer0_clear) |
                       timer0_set_i) & MASK_TIMER0;
  end

  // Timer 1 flags; a set in the clearing cycle survives
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer1_flags <= RESET_BYTE;
    else
      timer1_flags <= ((timer1_flags & ~timer1_clear) |
                       timer1_set_i) & MASK_TIMER1;
  end

  assign timer0_flags_o = timer0_flags;
  assign timer1_flags_o = timer1_flags;

  // Answer strobe and refusal, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_ack_o <= 1'b0;
      acc_err_o <= 1'b0;
    end
    else
    begin
      acc_ack_o <= acc_valid_i;
      acc_err_o <= acc_valid_i && refuse;
    end
  end

  // Read data, zero for writes, refusals and the extended area
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_rdata_o <= RESET_BYTE;
    else if (acc_valid_i)
      acc_rdata_o <= (io_ok && (is_read || is_skip)) ? rd_val : RESET_BYTE;
  end

  // Single-bit test for conditional skip
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_skip_o <= 1'b0;
    else if (acc_valid_i)
    begin
      if (io_ok && acc_op_i == SKIP_IF_BIT_SET)
        acc_skip_o <= |(rd_val & bit_mask);
      else if (io_ok && acc_op_i == SKIP_IF_BIT_CLEAR)
        acc_skip_o <= ~|(rd_val & bit_mask);
      else
        acc_skip_o <= 1'b0;
    end
  end

endmodule

// file: dv/lio_regs_props.sv
// Concurrent checks on the ports of the low I/O register block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module lio_regs_props
  import lio_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Reset
  input wire logic acc_valid_i, // Request
  input wire lio_op_type acc_op_i, // Access kind
  input wire logic [15:0] acc_addr_i, // Address
  input wire logic [2:0] acc_bit_i, // Bit number
  input wire logic [7:0] acc_wdata_i, // Write data
  input wire logic acc_ack_o, // Answer
  input wire logic acc_skip_o, // Skip decision
  input wire logic acc_err_o, // Refusal
  input wire logic [7:0] timer0_set_i, // Timer 0 set pulses
  input wire logic [7:0] timer0_flags_o, // Timer 0 flags
  input wire logic [7:0] timer1_flags_o, // Timer 1 flags
  input wire logic [7:0] pin_b_o, // Port B drive
  input wire logic [7:0] pin_b_oe_o, // Port B enable
  input wire logic [7:0] pin_f_o, // Port F drive
  input wire logic [7:0] pin_f_oe_o // Port F enable
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request classes
  wire bit_op = acc_valid_i && acc_op_i[2];
  wire mem_op = acc_valid_i && acc_op_i[2:1] == 2'h1;
  wire io_op = acc_valid_i && acc_op_i[2:1] == 2'h0;
  sequence s_skip_req;
    acc_valid_i && acc_op_i == SKIP_IF_BIT_SET && acc_addr_i == 16'h0004;
  endsequence
  sequence s_t0_clear;
    acc_valid_i && acc_op_i == IO_WRITE_OP && acc_addr_i == 16'h0015
      && acc_wdata_i[0] && !timer0_set_i[0];
  endsequence
  // Properties
  property p_bit_err;
    bit_op && acc_addr_i > 16'h001F |=> acc_ack_o && acc_err_o;
  endproperty
  property p_bit_ok;
    bit_op && acc_addr_i <= 16'h001F |=> acc_ack_o && !acc_err_o;
  endproperty
  property p_skip;
    s_skip_req |=> acc_skip_o == pin_b_oe_o[$past(acc_bit_i)];
  endproperty
  property p_w1c;
    s_t0_clear |=> !timer0_flags_o[0];
  endproperty
  property p_set;
    timer0_set_i[0] |=> timer0_flags_o[0];
  endproperty
  property p_io_err;
    io_op && acc_addr_i >= 16'h0040 |=> acc_err_o;
  endproperty
  property p_mem_low;
    mem_op && acc_addr_i < 16'h0020 |=> acc_err_o;
  endproperty
  property p_ext;
    mem_op && acc_addr_i inside {[16'h0060:16'h01FF]}
      |=> acc_ack_o && !acc_err_o;
  endproperty
  property p_wr_b;
    acc_valid_i && acc_op_i == IO_WRITE_OP && acc_addr_i == 16'h0005
      |=> pin_b_o == $past(acc_wdata_i);
  endproperty
  property p_t0_mask;
    (timer0_flags_o & 8'hF8) == 8'h00;
  endproperty
  property p_t1_mask;
    (timer1_flags_o & 8'hD0) == 8'h00;
  endproperty
  property p_f_mask;
    ((pin_f_o | pin_f_oe_o) & 8'h0C) == 8'h00;
  endproperty
  a_bit_err: assert property (p_bit_err)
    else $error("bit access above 0x1F not refused");
  a_bit_ok: assert property (p_bit_ok)
    else $error("bit access in range refused");
  a_skip: assert property (p_skip)
    else $error("skip decision differs from tested bit");
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by written one");
  a_set: assert property (p_set)
    else $error("flag not set by event");
  a_io_err: assert property (p_io_err)
    else $error("I/O access above 64 locations not refused");
  a_mem_low: assert property (p_mem_low)
    else $error("data access below offset not refused");
  a_ext: assert property (p_ext)
    else $error("extended area data access refused");
  a_wr_b: assert property (p_wr_b)
    else $error("port B output not written");
  a_t0_mask: assert property (p_t0_mask)
    else $error("timer 0 unused flag bit set");
  a_t1_mask: assert property (p_t1_mask)
    else $error("timer 1 unused flag bit set");
  a_f_mask: assert property (p_f_mask)
    else $error("port F absent bit driven");
endmodule
bind lio_regs lio_regs_props lio_regs_props_inst (.clk_i, .rst_i,
  .acc_valid_i, .acc_op_i, .acc_addr_i, .acc_bit_i, .acc_wdata_i,
  .acc_ack_o, .acc_skip_o, .acc_err_o, .timer0_set_i, .timer0_flags_o,
  .timer1_flags_o, .pin_b_o, .pin_b_oe_o, .pin_f_o, .pin_f_oe_o);

// file: dv/lio_regs_bench.sv
// Self-checking bench for the low I/O register block.
// Assumes the bound checker; inputs change at the falling edge.
`timescale 1ns/1ns
module lio_regs_bench
  import lio_pkg::*;
;
  localparam logic [7:0] MASKS [5] = '{MASK_PORT_B, MASK_PORT_C,
    MASK_PORT_D, MASK_PORT_E, MASK_PORT_F};
  logic clk_i, rst_i, acc_valid_i, acc_ack_o, acc_skip_o, acc_err_o;
  lio_op_type acc_op_i;
  logic [15:0] acc_addr_i;
  logic [2:0] acc_bit_i;
  logic [7:0] acc_wdata_i, acc_rdata_o, timer0_set_i, timer1_set_i;
  logic [7:0] timer0_flags_o, timer1_flags_o;
  logic [7:0] pin_in [5];
  logic [7:0] pout [5];
  logic [7:0] poe [5];
  int fails = 0;
  int check_count = 0;
  lio_regs lio_regs_inst (.clk_i, .rst_i, .acc_valid_i, .acc_op_i,
    .acc_addr_i, .acc_bit_i, .acc_wdata_i, .acc_ack_o, .acc_rdata_o,
    .acc_skip_o, .acc_err_o, .timer0_set_i, .timer1_set_i,
    .timer0_flags_o, .timer1_flags_o,
    .pin_b_i(pin_in[0]), .pin_b_o(pout[0]), .pin_b_oe_o(poe[0]),
    .pin_c_i(pin_in[1]), .pin_c_o(pout[1]), .pin_c_oe_o(poe[1]),
    .pin_d_i(pin_in[2]), .pin_d_o(pout[2]), .pin_d_oe_o(poe[2]),
    .pin_e_i(pin_in[3]), .pin_e_o(pout[3]), .pin_e_oe_o(poe[3]),
    .pin_f_i(pin_in[4]), .pin_f_o(pout[4]), .pin_f_oe_o(poe[4]));
  // Byte comparison with error count
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One access: request for one cycle, answer checked a cycle later
  task automatic acc(input lio_op_type o, input logic [15:0] a,
    input logic [2:0] b, input logic [7:0] d, input logic e);
    @(negedge clk_i);
    acc_valid_i = 1'b1;
    acc_op_i = o;
    acc_addr_i = a;
    acc_bit_i = b;
    acc_wdata_i = d;
    @(negedge clk_i);
    acc_valid_i = 1'b0;
    chk("ack", 8'h01, {7'h00, acc_ack_o});
    chk("err", {7'h00, e}, {7'h00, acc_err_o});
  endtask
  // Every location from 0x03 to 0x16 reads zero after reset
  task automatic t_reset;
    for (int i = 3; i <= 16'h16; i++)
    begin
      acc(IO_READ_OP, 16'(i), 3'h0, 8'h00, 1'b0);
      chk("reset", RESET_BYTE, acc_rdata_o);
    end
  endtask
  // Output, direction and input of each port, mixing both spaces
  task automatic t_ports;
    logic [7:0] m;
    logic [15:0] o;
    for (int i = 0; i < 5; i++)
    begin
      m = MASKS[i];
      o = 16'h0005 + 16'(3 * i);
      acc(IO_WRITE_OP, o, 3'h0, m, 1'b0);
      acc(MEMORY_WRITE_OP, o + 16'h001F, 3'h0, 8'h5A & m, 1'b0);
      acc(MEMORY_READ_OP, o + 16'h0020, 3'h0, 8'h00, 1'b0);
      chk("output", m, acc_rdata_o);
      chk("pin drive", m, pout[i]);
      chk("pin enable", 8'h5A & m, poe[i]);
      pin_in[i] = 8'hA5;
      acc(IO_WRITE_OP, o - 16'h0002, 3'h0, 8'h00, 1'b0);
      acc(IO_READ_OP, o - 16'h0002, 3'h0, 8'h00, 1'b0);
      chk("input", 8'hA5 & m, acc_rdata_o);
    end
  endtask
  // Single-bit set, clear and skip tests, and the range limit
  task automatic t_bits;
    acc(BIT_CLEAR_OP, 16'h000B, 3'h7, 8'h00, 1'b0);
    acc(IO_READ_OP, 16'h000B, 3'h0, 8'h00, 1'b0);
    chk("bit clear", 8'h7F, acc_rdata_o);
    acc(BIT_SET_OP, 16'h000B, 3'h7, 8'h00, 1'b0);
    chk("bit set", 8'hFF, pout[2]);
    acc(SKIP_IF_BIT_SET, 16'h0004, 3'h1, 8'h00, 1'b0);
    chk("skip set", 8'h01, {7'h00, acc_skip_o});
    acc(SKIP_IF_BIT_SET, 16'h0004, 3'h0, 8'h00, 1'b0);
    chk("no skip", 8'h00, {7'h00, acc_skip_o});
    acc(SKIP_IF_BIT_CLEAR, 16'h0004, 3'h0, 8'h00, 1'b0);
    chk("skip clear", 8'h01, {7'h00, acc_skip_o});
    acc(SKIP_IF_BIT_SET, 16'h001F, 3'h0, 8'h00, 1'b0);
    acc(BIT_SET_OP, 16'h0020, 3'h0, 8'h00, 1'b1);
  endtask
  // Flag setting, write-one clearing and read-modify-write side effect
  task automatic t_flags;
    @(negedge clk_i);
    timer0_set_i = 8'hFF;
    timer1_set_i = 8'hFF;
    @(negedge clk_i);
    timer0_set_i = 8'h00;
    timer1_set_i = 8'h00;
    chk("timer0 flags", MASK_TIMER0, timer0_flags_o);
    chk("timer1 flags", MASK_TIMER1, timer1_flags_o);
    acc(IO_WRITE_OP, 16'h0015, 3'h0, 8'h00, 1'b0);
    chk("zero write", 8'h07, timer0_flags_o);
    acc(IO_WRITE_OP, 16'h0015, 3'h0, 8'h01, 1'b0);
    chk("one write", 8'h06, timer0_flags_o);
    acc(BIT_CLEAR_OP, 16'h0015, 3'h1, 8'h00, 1'b0);
    chk("clear side", 8'h02, timer0_flags_o);
    acc(BIT_SET_OP, 16'h0016, 3'h3, 8'h00, 1'b0);
    chk("set side", 8'h00, timer1_flags_o);
  endtask
  // Address space limits of I/O, data-space and skip-if-bit-clear accesses
  task automatic t_space;
    acc(IO_READ_OP, 16'h003F, 3'h0, 8'h00, 1'b0);
    acc(IO_WRITE_OP, 16'h0040, 3'h0, 8'h00, 1'b1);
    acc(MEMORY_READ_OP, 16'h001F, 3'h0, 8'h00, 1'b1);
    acc(MEMORY_WRITE_OP, 16'h0060, 3'h0, 8'h00, 1'b0);
    acc(MEMORY_READ_OP, 16'h01FF, 3'h0, 8'h00, 1'b0);
    chk("ext read", 8'h00, acc_rdata_o);
    acc(MEMORY_READ_OP, 16'h0200, 3'h0, 8'h00, 1'b1);
    acc(SKIP_IF_BIT_CLEAR, 16'h0060, 3'h0, 8'h00, 1'b1);
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    acc_valid_i = 1'b0;
    acc_op_i = IO_READ_OP;
    acc_addr_i = 16'h0000;
    acc_bit_i = 3'h0;
    acc_wdata_i = 8'h00;
    timer0_set_i = 8'h00;
    timer1_set_i = 8'h00;
    for (int i = 0; i < 5; i++)
      pin_in[i] = 8'h00;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset;
    t_ports;
    t_bits;
    t_flags;
    t_space;
    end_of_test;
  end
endmodule
